// >>> design/drive_option_logic.sv
// Summary of operation
// - Standard setup: select loads heads and powers the stepper.
// - Select-without-load: select alone keeps heads up; head load loads and powers stepper.
// - Stepper-on-select: selected drive steps with heads up or door open.
// - Standard setup: steps honoured only with door closed and heads loaded.
// - Load-without-select: selected only with drive select and head load both active.
// - Radial ready: ready shown on its own line at all times.
// - Radial index/sector: pulses shown on own lines regardless of select.
// - Low activity-hold input lights the lamp and locks the door.
// - Lamp is activity-hold OR select OR head load; lock is the lamp OR the door latch.
// - Default: a protected diskette blocks writing.
// - Report option: protected diskette no longer blocks, but is still reported.
// - Change option: change output low on select after ready fell while deselected.
// - Change output clears on select release once the drive is ready again.
// - Direction side mode: direction steers stepping and picks the side for read/write.
// - Select side mode: lines 1,2 are sides 0,1 of drive one; 3,4 of two.
// - Door latch: select with activity-hold sets latch; without it clears latch.
// - Two-sided status true for two-sided media, false for single-sided.
// - Writing with current switch low picks low write current on tracks 43 to 76.
// - Current switch means write current when writing, read filter when reading.
// - Current switch strapped to ground always gives the low write current.
// - Reading with current switch low filters read data on tracks 60 to 76.
module drive_option_logic #(
  parameter int unsigned LOAD_SETTLE_CYCLES = drive_opt_pkg::LOAD_SETTLE_CYC,
  parameter int unsigned SEL_SETTLE_CYCLES = drive_opt_pkg::SEL_SETTLE_CYC
) (
  input wire logic clk, // Core clock, 10 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire drive_opt_pkg::option_cfg_t straps, // Option straps.
  input wire drive_opt_pkg::host_in_t host_in, // Controller cable inputs.
  input wire drive_opt_pkg::media_in_t media_in, // Drive sensors.
  input wire logic [7:0] addr, // Register byte address.
  input wire logic [31:0] wdata, // Register write data.
  input wire logic wr, // Register write strobe.
  input wire logic rd, // Register read strobe.
  output logic [31:0] rdata, // Read data, valid the cycle after rd.
  output drive_opt_pkg::host_out_t host_out, // Controller cable outputs.
  output drive_opt_pkg::mech_out_t mech_out // Mechanism drives.
);

  typedef struct packed {
    drive_opt_pkg::option_cfg_t cfg;
    logic captured;
    logic sel_q;
    logic step_q;
    logic ready_q;
    logic pending;
    logic lock_latch;
    logic [19:0] load_cnt;
    logic [19:0] sel_cnt;
    drive_opt_pkg::host_out_t pins;
    drive_opt_pkg::mech_out_t mech;
    logic [31:0] rdata;
  } state_t;

  localparam logic [19:0] LOAD_SETTLE = 20'(LOAD_SETTLE_CYCLES);
  localparam logic [19:0] SEL_SETTLE = 20'(SEL_SETTLE_CYCLES);

  state_t s_reg;
  state_t s_next;
  logic [6:0] track;

  // The counter moves on the edge that ends the step pulse.
  track_counter u_track (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .step(s_reg.mech.step),
    .step_in(s_reg.mech.step_in),
    .at_zero(media_in.track0),
    .track(track)
  );

  always_comb begin
    drive_opt_pkg::option_cfg_t c;
    logic hl;
    logic iu;
    logic sel_line;
    logic side_line;
    logic sel;
    logic load;
    logic stepper;
    logic seek_ok;
    logic step_edge;
    logic sel_rise;
    logic sel_fall;
    logic ready_fall;
    logic cs_low;
    logic band_low;
    logic band_filt;
    logic wen;
    logic reading;
    logic lamp;
    logic [31:0] rd_val;
    // Every local starts defined, so no path leaves a latch.
    c = s_reg.cfg;
    s_next = s_reg;
    sel_line = 1'b0;
    side_line = 1'b0;
    sel = 1'b0;
    load = 1'b0;
    stepper = 1'b0;
    seek_ok = 1'b0;
    step_edge = 1'b0;
    sel_rise = 1'b0;
    sel_fall = 1'b0;
    ready_fall = 1'b0;
    cs_low = 1'b0;
    band_low = 1'b0;
    band_filt = 1'b0;
    wen = 1'b0;
    reading = 1'b0;
    lamp = 1'b0;
    rd_val = '0;

    // Cable lines are active low; work active high from here.
    hl = !host_in.head_load_n;
    // Activity hold counts only when wired to the lamp circuit.
    iu = c.activity_circuit_node && !host_in.in_use_n;

    // Which select line addresses this drive.
    // In select side mode a unit answers to a pair of lines.
    if (c.side_by_select_strap) begin
      sel_line = !host_in.drive_sel_n[{c.drive_addr[1], 1'b0}] ||
                 !host_in.drive_sel_n[{c.drive_addr[1], 1'b1}];
      side_line = !host_in.drive_sel_n[{c.drive_addr[1], 1'b1}];
    end else begin
      sel_line = !host_in.drive_sel_n[c.drive_addr];
      side_line = 1'b0;
    end

    // With load-without-select a lone select line does not count.
    if (c.load_no_select) begin
      sel = sel_line && hl;
    end else begin
      sel = sel_line;
    end
    // Head load and stepper power per option.
    if (c.load_no_select) begin
      load = hl;
      stepper = sel;
    end else if (c.sel_no_load) begin
      load = sel && hl;
      stepper = sel && hl;
    end else if (c.stepper_on_select) begin
      load = sel && hl;
      stepper = sel;
    end else begin
      load = sel;
      stepper = sel;
    end
    // Seeks need a shut door and loaded heads unless the option lifts both.
    if (c.stepper_on_select) begin
      seek_ok = stepper;
    end else begin
      seek_ok = stepper && media_in.door_closed && load;
    end

    // The step history resets high, the idle pin level, so reset gives no step.
    // Edges compare against the previous enabled cycle.
    step_edge = s_reg.step_q && !host_in.step_n;
    sel_rise = sel && !s_reg.sel_q;
    sel_fall = !sel && s_reg.sel_q;
    ready_fall = s_reg.ready_q && !media_in.ready;
    s_next.step_q = host_in.step_n;
    s_next.sel_q = sel;
    s_next.ready_q = media_in.ready;

    // Settle timers give software a view of the controller's waits.
    // The load timer restarts when the heads lift and stops at its limit.
    if (!load) begin
      s_next.load_cnt = '0;
    end else if (s_reg.load_cnt != LOAD_SETTLE) begin
      s_next.load_cnt = s_reg.load_cnt + 20'h00001;
    end

    // The select timer runs only while selected with heads loaded.
    if (!sel || !load) begin
      s_next.sel_cnt = '0;
    end else if (s_reg.sel_cnt != SEL_SETTLE) begin
      s_next.sel_cnt = s_reg.sel_cnt + 20'h00001;
    end

    // Write path with protect handling.
    if (c.protect_report_strap) begin
      wen = sel && load && !host_in.write_gate_n;
    end else begin
      wen = sel && load && !host_in.write_gate_n && !media_in.protect;
    end

    // A loaded, selected drive with the gate off is reading.
    reading = sel && load && host_in.write_gate_n;
    // A grounded current switch reads as always active.
    cs_low = c.current_sw_grounded || !host_in.write_current_level_input;
    // The bands use the track that stands now.
    band_low = track >= drive_opt_pkg::LOW_CUR_FIRST &&
               track <= drive_opt_pkg::LAST_TRACK;
    band_filt = track >= drive_opt_pkg::FILTER_FIRST &&
                track <= drive_opt_pkg::LAST_TRACK;

    // Door latch follows activity-hold at each select.
    // Without the hold input wired in, the latch stays clear.
    if (!(c.door_latch_option && c.activity_circuit_node)) begin
      s_next.lock_latch = 1'b0;
    end else if (sel_rise) begin
      s_next.lock_latch = iu;
    end

    // The lamp follows the cable lines, not the head state.
    lamp = iu || sel || hl;

    // Media change flag; a fall in the deselect cycle is kept, set wins.
    s_next.pins.change_n = s_reg.pins.change_n;
    if (!c.media_swap_flag_option) begin
      s_next.pending = 1'b0;
      s_next.pins.change_n = 1'b1;
    end else begin
      // Selecting with a pending flag shows the change line.
      if (sel_rise && s_reg.pending) begin
        s_next.pins.change_n = 1'b0;
        s_next.pending = 1'b0;
      end
      // Only a fall seen while deselected arms the flag.
      if (ready_fall && !sel) begin
        s_next.pending = 1'b1;
      end
      // Release with the drive ready again drops the line.
      if (sel_fall && media_in.ready) begin
        s_next.pins.change_n = 1'b1;
      end
    end

    // Side choice.
    if (c.side_by_select_strap) begin
      s_next.mech.side = side_line;
    end else if (c.side_by_direction_strap) begin
      // The side holds through a step so the pulse cannot flip it.
      if (!step_edge) begin
        s_next.mech.side = !host_in.direction_n;
      end
    end else begin
      s_next.mech.side = !host_in.side_sel_n;
    end

    s_next.mech.head_load = load;
    s_next.mech.stepper_en = stepper;
    s_next.mech.step = step_edge && seek_ok;
    s_next.mech.step_in = !host_in.direction_n;
    s_next.mech.write_en = wen;
    // Low current is banded unless the switch is grounded.
    s_next.mech.low_current = wen &&
      (c.current_sw_grounded || (cs_low && band_low));
    s_next.mech.read_filter = reading && cs_low && band_filt;
    s_next.mech.lamp = lamp;
    // The latch keeps the door locked after the lamp is out.
    s_next.mech.door_lock = lamp || s_reg.lock_latch;


    // Shared lines answer only while selected.
    s_next.pins.ready_n = !(sel && media_in.ready);
    s_next.pins.index_n = !(sel && media_in.index);
    s_next.pins.sector_n = !(sel && media_in.sector);
    s_next.pins.radial_ready_n = !(c.per_drive_ready_option && media_in.ready);
    s_next.pins.radial_index_n = !(c.per_drive_pulse_option && media_in.index);
    s_next.pins.radial_sector_n = !(c.per_drive_pulse_option && media_in.sector);

    // Protect is reported when selected, in every write mode.
    s_next.pins.protect_n = !(sel && media_in.protect);
    s_next.pins.two_sided_n = !(c.double_sided_status_option && sel &&
                                media_in.two_sided);
    s_next.pins.track0_n = !(sel && media_in.track0);

    // Register port.
    rd_val = '0;
    unique case (addr)
      drive_opt_pkg::CONFIG_OFS: begin
        rd_val[drive_opt_pkg::CFG_W-1:0] = s_reg.cfg;
      end

      drive_opt_pkg::STATUS_OFS: begin
        rd_val[drive_opt_pkg::ST_SEL_BIT] = s_reg.sel_q;
        rd_val[drive_opt_pkg::ST_PEND_BIT] = s_reg.pending;
        rd_val[drive_opt_pkg::ST_LATCH_BIT] = s_reg.lock_latch;
        rd_val[drive_opt_pkg::ST_LOAD_OK_BIT] = s_reg.load_cnt == LOAD_SETTLE;
        rd_val[drive_opt_pkg::ST_SEL_OK_BIT] = s_reg.sel_cnt == SEL_SETTLE;
        rd_val[drive_opt_pkg::ST_MECH_LSB +: drive_opt_pkg::MECH_W] = s_reg.mech;
        rd_val[drive_opt_pkg::ST_PINS_LSB +: drive_opt_pkg::PINS_W] = s_reg.pins;
      end

      drive_opt_pkg::TRACK_OFS: begin
        rd_val[drive_opt_pkg::TRACK_W-1:0] = track;
      end

      // Unmapped offsets read as zero.
      default: begin
        rd_val = '0;
      end
    endcase
    // Read data stand for one cycle and are zero otherwise.
    if (rd) begin
      s_next.rdata = rd_val;
    end else begin
      s_next.rdata = 32'h0000_0000;
    end

    // Straps are taken on the first enabled edge after reset release.
    if (!s_reg.captured) begin
      s_next.cfg = straps;
      s_next.captured = 1'b1;
    end
    // A software write beats the straps, even in the capture cycle.
    if (wr && addr == drive_opt_pkg::CONFIG_OFS) begin
      s_next.cfg = wdata[drive_opt_pkg::CFG_W-1:0];
    end
  end

  // Reset acts on any edge, whatever the clock enable.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.cfg <= drive_opt_pkg::CFG_DEFAULT;
      s_reg.sel_q <= 1'b0;
      s_reg.step_q <= 1'b1;
      s_reg.pins <= drive_opt_pkg::PINS_IDLE;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from the state register.
  assign rdata = s_reg.rdata;
  assign host_out = s_reg.pins;
  assign mech_out = s_reg.mech;

endmodule // drive_option_logic

// >>> design/track_counter.sv
module track_counter (
  input wire logic clk, // Core clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic step, // One accepted step.
  input wire logic step_in, // Step toward the spindle.
  input wire logic at_zero, // Track zero sensor.
  output logic [6:0] track // Current head track.
);

  typedef struct packed {
    logic [6:0] track;
  } trk_state_t;

  trk_state_t s_reg;
  trk_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (step) begin
      if (step_in && s_reg.track != drive_opt_pkg::LAST_TRACK) begin
        s_next.track = s_reg.track + 7'h01;
      end else if (!step_in && s_reg.track != 7'h00) begin
        s_next.track = s_reg.track - 7'h01;
      end
    end
    // The sensor wins so a recalibrate always lands on zero.
    if (at_zero) begin
      s_next.track = 7'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign track = s_reg.track;

endmodule // track_counter

// >>> dv/ctrl_model.sv
module ctrl_model #(
  parameter int unsigned LOAD_WAIT = 20,
  parameter int unsigned SEL_WAIT = 6
) (
  input wire logic clk, // Core clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic [3:0] sel, // Select lines wanted.
  input wire logic load, // Head load wanted.
  input wire logic hold, // Activity hold wanted.
  input wire logic dir_in, // Step toward spindle.
  input wire logic step_req, // Step strobe.
  input wire logic wg_req, // Write wanted.
  input wire logic cur_low, // Current switch low.
  output drive_opt_pkg::host_in_t host_in // Cable lines.
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned load_cnt;
  int unsigned sel_cnt;
  always_ff @(posedge clk) begin
    load_cnt <= (!rst_n || !load) ? 0 : ((load_cnt < LOAD_WAIT) ? load_cnt + 1 : load_cnt);
    sel_cnt <= (!rst_n || sel == 4'h0) ? 0 : ((sel_cnt < SEL_WAIT) ? sel_cnt + 1 : sel_cnt);
  end
  always_comb begin
    host_in = '1;
    host_in.drive_sel_n = ~sel;
    host_in.head_load_n = !load;
    host_in.in_use_n = !hold;
    host_in.direction_n = !dir_in;
    host_in.step_n = !step_req;
    // Write gate is held off until heads and select have settled.
    host_in.write_gate_n = !(wg_req && load_cnt >= LOAD_WAIT && sel_cnt >= SEL_WAIT);
    host_in.write_current_level_input = !cur_low;
  end
endmodule // ctrl_model

// >>> dv/drive_opt_chk.sv
module drive_opt_chk #(
  parameter int unsigned LOAD_SETTLE_CYCLES = 20,
  parameter int unsigned SEL_SETTLE_CYCLES = 6
) (
  input wire logic clk, // Core clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic ce, // Clock enable.
  input wire drive_opt_pkg::option_cfg_t straps, // Straps.
  input wire drive_opt_pkg::host_in_t host_in, // Cable inputs.
  input wire drive_opt_pkg::media_in_t media_in, // Sensors.
  input wire logic [7:0] addr, // Register address.
  input wire logic [31:0] wdata, // Write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  input wire logic [31:0] rdata, // Read data.
  input wire drive_opt_pkg::host_out_t host_out, // Cable outputs.
  input wire drive_opt_pkg::mech_out_t mech_out // Mechanism drives.
);
  timeunit 1ns;
  timeprecision 1ns;
  drive_opt_pkg::option_cfg_t cfg_q;
  logic cap_q;
  logic cause;
  assign cause = !host_in.in_use_n || host_in.drive_sel_n != 4'hf || !host_in.head_load_n;
  // Mirrors the option word: straps on the first edge after reset, then CONFIG writes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q <= drive_opt_pkg::CFG_DEFAULT;
      cap_q <= 1'b1;
    end else if (ce) begin
      cap_q <= 1'b0;
      if (wr && addr == drive_opt_pkg::CONFIG_OFS) begin
        cfg_q <= wdata[15:0];
      end else if (cap_q) begin
        cfg_q <= straps;
      end
    end
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_hold_lamp: assert property (
    cfg_q.activity_circuit_node && !host_in.in_use_n |=> mech_out.lamp && mech_out.door_lock)
    else $error("lamp or lock off while activity hold low");
  a_lamp_cause: assert property (
    !cause |=> !$rose(mech_out.lamp))
    else $error("lamp lit without any cause");
  a_seek_door: assert property (
    !cfg_q.stepper_on_select && !media_in.door_closed |=> !mech_out.step)
    else $error("step honoured with door open");
  a_seek_unloaded: assert property (
    cfg_q.stepper_on_select && !cfg_q.load_no_select && !cfg_q.side_by_select_strap
    && !host_in.drive_sel_n[cfg_q.drive_addr] && $fell(host_in.step_n) |=> mech_out.step)
    else $error("step dropped on selected drive");
  a_protect_block: assert property (
    !cfg_q.protect_report_strap && media_in.protect |=> !mech_out.write_en)
    else $error("write enabled on protected media");
  a_change_off: assert property (
    !cfg_q.media_swap_flag_option |=> host_out.change_n)
    else $error("change line low with option off");
  a_radial_ready: assert property (
    cfg_q.per_drive_ready_option |=> host_out.radial_ready_n == !$past(media_in.ready))
    else $error("radial ready does not follow sensor");
  a_radial_pulse: assert property (
    cfg_q.per_drive_pulse_option |=> host_out.radial_index_n == !$past(media_in.index)
    && host_out.radial_sector_n == !$past(media_in.sector))
    else $error("radial pulses do not follow sensor");
  a_side_select: assert property (
    cfg_q.side_by_select_strap && !cfg_q.side_by_direction_strap
    && !host_in.drive_sel_n[{cfg_q.drive_addr[1], 1'b1}]
    && host_in.drive_sel_n[{cfg_q.drive_addr[1], 1'b0}] |=> mech_out.side)
    else $error("side one line did not pick side one");
endmodule // drive_opt_chk

bind drive_option_logic drive_opt_chk #(
  .LOAD_SETTLE_CYCLES(LOAD_SETTLE_CYCLES),
  .SEL_SETTLE_CYCLES(SEL_SETTLE_CYCLES)
) drive_opt_chk_inst (
  .clk(clk), .rst_n(rst_n), .ce(ce), .straps(straps), .host_in(host_in),
  .media_in(media_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .host_out(host_out), .mech_out(mech_out)
);

// >>> dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned LW = 20;
  localparam int unsigned SW = 6;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0] sel = 4'h0;
  logic load = 1'b0, hold = 1'b0, dir_in = 1'b0, step_req = 1'b0, wg_req = 1'b0;
  logic cur_low = 1'b0, lo;
  drive_opt_pkg::option_cfg_t straps = '0;
  drive_opt_pkg::media_in_t media_in = '0, m;
  drive_opt_pkg::host_in_t host_in;
  drive_opt_pkg::host_out_t host_out;
  drive_opt_pkg::mech_out_t mech_out;
  int trk = 0, num_errors = 0, samples_checked = 0;

  ctrl_model #(.LOAD_WAIT(LW), .SEL_WAIT(SW)) ctrl_model_inst (.clk(clk), .rst_n(rst_n),
    .sel(sel), .load(load), .hold(hold), .dir_in(dir_in), .step_req(step_req),
    .wg_req(wg_req), .cur_low(cur_low), .host_in(host_in));
  drive_option_logic #(.LOAD_SETTLE_CYCLES(LW), .SEL_SETTLE_CYCLES(SW)) drive_option_logic_inst (
    .clk(clk), .rst_n(rst_n), .ce(ce), .straps(straps), .host_in(host_in),
    .media_in(media_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .host_out(host_out), .mech_out(mech_out));

  initial begin
    forever #50 clk = ~clk;
  end

  function automatic int nxt(int t, logic d, logic ok);
    if (!ok) return t;
    return d ? ((t < 76) ? t + 1 : t) : ((t > 0) ? t - 1 : 0);
  endfunction
  function automatic logic band(int t, int first, logic on);
    return on && t >= first && t <= int'(drive_opt_pkg::LAST_TRACK);
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask
  task automatic setcfg(logic [15:0] c);
    bus(1'b1, drive_opt_pkg::CONFIG_OFS, {16'h0, c});
    wt(2);
  endtask
  task automatic req(logic [3:0] s, logic l, logic h);
    @(posedge clk);
    sel <= s;
    load <= l;
    hold <= h;
    wt(2);
  endtask
  task automatic med(drive_opt_pkg::media_in_t v);
    @(posedge clk);
    media_in <= v;
    wt(2);
  endtask
  task automatic wgate(logic g, int n);
    @(posedge clk);
    wg_req <= g;
    wt(n);
  endtask
  task automatic seek(logic d, logic ok);
    @(posedge clk);
    dir_in <= d;
    @(posedge clk);
    step_req <= 1'b1;
    @(posedge clk);
    step_req <= 1'b0;
    wt(4);
    trk = nxt(trk, d, ok);
    bus(1'b0, drive_opt_pkg::TRACK_OFS, 32'h0);
    check("track", rv, 32'(trk));
  endtask
  task automatic done(string n);
    $display("test %s done", n);
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("watchdog expired");
    conclude();
  end

  initial begin
    rv = $urandom(61235);
    straps = 16'($urandom);
    wt(6);
    check("pins idle", host_out, drive_opt_pkg::PINS_IDLE);
    check("mech idle", mech_out, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    wt(1);
    bus(1'b0, drive_opt_pkg::CONFIG_OFS, 32'h0);
    check("config", rv, {16'h0, straps});
    bus(1'b0, 8'hfc, 32'h0);
    check("unmapped", rv, 32'h0);
    done("reset");
    setcfg(16'h0000);
    med(7'h20);
    req(4'h1, 1'b0, 1'b0);
    check("select", {mech_out.head_load, mech_out.stepper_en, mech_out.lamp}, 3'h7);
    seek(1'b1, 1'b0);
    med(7'h60);
    seek(1'b1, 1'b1);
    done("standard");
    setcfg(16'h2000);
    check("unloaded", {mech_out.head_load, mech_out.stepper_en}, 2'b00);
    check("ready shown", host_out.ready_n, 1'b0);
    req(4'h1, 1'b1, 1'b0);
    check("loaded", {mech_out.head_load, mech_out.stepper_en}, 2'b11);
    setcfg(16'h1000);
    med(7'h20);
    req(4'h1, 1'b0, 1'b0);
    seek(1'b1, 1'b1);
    seek(1'b0, 1'b1);
    done("select options");
    setcfg(16'h0800);
    med(7'h60);
    for (int i = 0; i < 4; i++) begin
      req({3'h0, i[0]}, i[1], 1'b0);
      check("ready gated", host_out.ready_n, i != 3);
    end
    setcfg(16'h0600);
    req(4'h0, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      m = 7'($urandom) & 7'h7e;
      med(m);
      check("radial", {host_out.radial_ready_n, host_out.radial_index_n,
        host_out.radial_sector_n}, {!m.ready, !m.index, !m.sector});
    end
    setcfg(16'h0100);
    for (int i = 0; i < 4; i++) begin
      req(4'h0, i[1], i[0]);
      check("lamp", mech_out.lamp, i != 0);
    end
    done("lines");
    for (int j = 0; j < 4; j++) begin
      setcfg(j[0] ? 16'h0080 : 16'h0000);
      med({4'hc, j[1], 2'b00});
      req(4'h1, 1'b1, 1'b0);
      wgate(1'b1, LW + SW + 2);
      check("write enable", mech_out.write_en, j[0] | !j[1]);
      check("protect", host_out.protect_n, !j[1]);
      wgate(1'b0, 2);
    end
    setcfg(16'h0040);
    req(4'h0, 1'b0, 1'b0);
    med(7'h60);
    med(7'h00);
    req(4'h1, 1'b0, 1'b0);
    check("change set", host_out.change_n, 1'b0);
    med(7'h60);
    req(4'h0, 1'b0, 1'b0);
    req(4'h1, 1'b0, 1'b0);
    check("change clear", host_out.change_n, 1'b1);
    done("protect and change");
    for (int i = 0; i < 4; i++) begin
      setcfg({i[1], 15'h0010});
      req(4'(1 << i), 1'b1, 1'b0);
      check("side by line", mech_out.side, i[0]);
    end
    setcfg(16'h0020);
    req(4'h1, 1'b1, 1'b0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      dir_in <= i[0];
      wt(2);
      check("side by dir", {mech_out.side, mech_out.step_in}, {i[0], i[0]});
    end
    setcfg(16'h0108);
    req(4'h0, 1'b0, 1'b0);
    req(4'h1, 1'b0, 1'b1);
    req(4'h0, 1'b0, 1'b0);
    check("latch set", mech_out.door_lock, 1'b1);
    req(4'h1, 1'b0, 1'b0);
    req(4'h0, 1'b0, 1'b0);
    check("latch clear", mech_out.door_lock, 1'b0);
    setcfg(16'h0004);
    req(4'h1, 1'b1, 1'b0);
    for (int i = 0; i < 2; i++) begin
      med({5'h18, i[0], 1'b0});
      check("two sided", host_out.two_sided_n, !i[0]);
    end
    done("sides and latch");
    setcfg(16'h0000);
    med(7'h60);
    while (trk < 61) begin
      seek(1'b1, 1'b1);
      lo = 1'($urandom);
      @(posedge clk);
      cur_low <= lo;
      wgate(1'b1, 3);
      check("low current", mech_out.low_current, band(trk, 43, lo));
      wgate(1'b0, 3);
      check("read filter", mech_out.read_filter, band(trk, 60, lo));
    end
    setcfg(16'h0002);
    @(posedge clk);
    cur_low <= 1'b0;
    wgate(1'b1, 3);
    check("grounded", mech_out.low_current, 1'b1);
    @(posedge clk);
    ce <= 1'b0;
    req(4'h0, 1'b0, 1'b0);
    check("frozen", mech_out.head_load, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    wt(2);
    check("thawed", mech_out.head_load, 1'b0);
    done("current");
    conclude();
  end
endmodule // tb

// >>> pkg/drive_opt_pkg.sv
package drive_opt_pkg;

  // Register map of the plain register port.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] CONFIG_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] TRACK_OFS = 8'h08;

  // Status register field positions.
  localparam int unsigned ST_SEL_BIT = 0;
  localparam int unsigned ST_PEND_BIT = 1;
  localparam int unsigned ST_LATCH_BIT = 2;
  localparam int unsigned ST_LOAD_OK_BIT = 3;
  localparam int unsigned ST_SEL_OK_BIT = 4;
  localparam int unsigned ST_MECH_LSB = 8;
  localparam int unsigned ST_PINS_LSB = 20;

  // Track geometry and current or filter bands.
  localparam int unsigned TRACK_W = 7;
  localparam logic [6:0] LAST_TRACK = 7'h4c;
  localparam logic [6:0] LOW_CUR_FIRST = 7'h2b;
  localparam logic [6:0] FILTER_FIRST = 7'h3c;

  // Settle times seen by the controller and their cycle counts at the core clock.
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned LOAD_SETTLE_MS = 50;
  localparam int unsigned SEL_SETTLE_MS = 15;
  localparam int unsigned LOAD_SETTLE_CYC = LOAD_SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned SEL_SETTLE_CYC = SEL_SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned SETTLE_W = 20;

  typedef struct packed {
    logic [1:0] drive_addr;
    logic sel_no_load;
    logic stepper_on_select;
    logic load_no_select;
    logic per_drive_ready_option;
    logic per_drive_pulse_option;
    logic activity_circuit_node;
    logic protect_report_strap;
    logic media_swap_flag_option;
    logic side_by_direction_strap;
    logic side_by_select_strap;
    logic door_latch_option;
    logic double_sided_status_option;
    logic current_sw_grounded;
    logic spare;
  } option_cfg_t;

  localparam int unsigned CFG_W = 16;
  localparam option_cfg_t CFG_DEFAULT = 16'h0008;

  typedef struct packed {
    logic [3:0] drive_sel_n;
    logic head_load_n;
    logic in_use_n;
    logic direction_n;
    logic step_n;
    logic write_gate_n;
    logic side_sel_n;
    logic write_current_level_input;
  } host_in_t;

  typedef struct packed {
    logic door_closed;
    logic ready;
    logic index;
    logic sector;
    logic protect;
    logic two_sided;
    logic track0;
  } media_in_t;

  typedef struct packed {
    logic ready_n;
    logic index_n;
    logic sector_n;
    logic radial_ready_n;
    logic radial_index_n;
    logic radial_sector_n;
    logic protect_n;
    logic change_n;
    logic two_sided_n;
    logic track0_n;
  } host_out_t;

  localparam int unsigned PINS_W = 10;
  localparam host_out_t PINS_IDLE = 10'h3ff;

  typedef struct packed {
    logic head_load;
    logic stepper_en;
    logic step;
    logic step_in;
    logic side;
    logic write_en;
    logic low_current;
    logic read_filter;
    logic lamp;
    logic door_lock;
  } mech_out_t;

  localparam int unsigned MECH_W = 10;

endpackage
